//--- rtl/radio_packet_framer_pkg.sv
// Constants and types shared by the radio packet framer
package radio_packet_framer_pkg;
  typedef enum logic [13:0] {
    F_IDLE = 14'h0001, F_PRE = 14'h0002, F_SYNC = 14'h0004,
    F_LEN = 14'h0008, F_DEST = 14'h0010, F_SRC = 14'h0020,
    F_CTRL = 14'h0040, F_SEQ = 14'h0080, F_PAY = 14'h0100,
    F_CRC = 14'h0200, F_MPRE = 14'h0400, F_MSYNC = 14'h0800,
    F_MBODY = 14'h1000, F_MPOST = 14'h2000
  } field_e;
  localparam logic [1:0] FMT_BASIC = 2'h0;
  localparam logic [1:0] FMT_METER = 2'h2;
  localparam logic [1:0] FMT_LINK = 2'h3;
  localparam logic [31:0] PRE_PATTERN = 32'haaaaaaaa;
  localparam logic [31:0] PAIR_PATTERN = 32'h55555555;
  localparam logic [23:0] CRC_INIT = 24'hffffff;
  localparam logic [23:0] POLY8 = 24'h000007;
  localparam logic [23:0] POLY16A = 24'h008005;
  localparam logic [23:0] POLY16B = 24'h001021;
  localparam logic [23:0] POLY24 = 24'h864cfb;
  localparam logic [2:0] SUB_S = 3'h0;
  localparam logic [2:0] SUB_SM = 3'h1;
  localparam logic [2:0] SUB_T = 3'h3;
  localparam logic [2:0] SUB_R = 3'h5;
  localparam logic [2:0] SUB_N = 3'h6;
  localparam logic [19:0] HDR_S = 20'd279;
  localparam logic [19:0] HDR_SM = 20'd15;
  localparam logic [19:0] HDR_T = 20'd19;
  localparam logic [19:0] HDR_R = 20'd39;
  localparam logic [19:0] HDR_N = 20'd8;
  localparam logic [31:0] MSYNC_LONG = 32'h00007696;
  localparam logic [31:0] MSYNC_SHORT = 32'h0000003d;
  localparam logic [31:0] MSYNC_N = 32'h0000f68d;
  localparam logic [19:0] MSYNC_LONG_BITS = 20'd18;
  localparam logic [19:0] MSYNC_SHORT_BITS = 20'd10;
  localparam logic [15:0] LINK_ADDR_BYTES = 16'd2;
  localparam logic [19:0] SEQ_BITS = 20'd3;
  localparam logic [19:0] ADDR_BITS = 20'd8;
  localparam logic [4:0] MAN_CHIPS = 5'd16;
  localparam logic [4:0] SIX_CHIPS = 5'd12;
  localparam logic [4:0] BYTE_BITS = 5'd8;
  localparam logic [5:0] SIX_TAB [16] = '{6'h16, 6'h0d, 6'h0e, 6'h0b,
    6'h1c, 6'h19, 6'h1a, 6'h13, 6'h2c, 6'h25, 6'h26, 6'h23, 6'h34,
    6'h31, 6'h32, 6'h29};
endpackage

//--- rtl/radio_packet_framer.sv
// Transmit framer and receive deframer for the packet radio
// Notes on behaviour
// - Format 0 is basic, 2 meter-bus, 3 link-layer; others idle.
// - Link and basic frames open with 1..32 bytes of 10101010.
// - Sync is 1..4 bytes, first N sync bytes sent in order.
// - Length counts address, control and payload; link address counts 2.
// - Receiver checks destination against own, broadcast, multicast.
// - Source sent from own address; receiver checks masked source.
// - Control field 0..4 bytes taken from four control bytes.
// - Two-bit sequence counts per sent link packet; reload command loads it.
// - Sent no-ack bit comes from the skip-ack setting.
// - Payload of 0..65535 bytes, fixed or variable length.
// - Transmit payload length is high byte times 256 plus low byte.
// - Receive length from the frame when variable, else from bytes.
// - Length field is setting plus one bits wide.
// - CRC of 8, 16 or 24 bits; bad CRC dropped when filtering.
// - Meter lead-in and trailer are repeated 01 chip pairs.
// - Meter body bytes use Manchester or 3-of-6 by submode.
// - Submodes 0 and 1 add 279 or 15 pairs, sync 0x7696.
// - Submode 3 adds 19 pairs, 10-bit sync 0x3d.
// - Submode 5 adds 39 pairs, 18-bit sync 0x7696.
// - Short N submode uses 8 pairs and sync 0xf68d.
// - CRC modes 1..4 select 0x07, 0x8005, 0x1021, 0x864cfb.
// - CRC starts all ones, unreflected, skips preamble and sync.
`timescale 1ns/1ns
module radio_packet_framer
  import radio_packet_framer_pkg::*;
(
  input wire logic I_SYS_CLK, // System clock
  input wire logic I_NRST, // Async reset, active low
  input wire logic [1:0] i_FRAME_FORMAT_SELECT, // Frame format
  input wire logic [4:0] i_PREAMBLE_BYTES_M1, // Preamble bytes minus one
  input wire logic [1:0] i_SYNC_BYTES_M1, // Sync bytes minus one
  input wire logic [7:0] i_SYNC_WORD_BYTE_A, // First sync byte
  input wire logic [7:0] i_SYNC_WORD_BYTE_B, // Second sync byte
  input wire logic [7:0] i_SYNC_WORD_BYTE_C, // Third sync byte
  input wire logic [7:0] i_SYNC_WORD_BYTE_D, // Fourth sync byte
  input wire logic i_VARIABLE_LENGTH_ENABLE, // Length field present
  input wire logic [3:0] i_LENGTH_FIELD_BITS_MINUS_ONE, // Length width
  input wire logic [1:0] i_ADDR_FIELD_BYTES, // Address bytes
  input wire logic [2:0] i_CTRL_FIELD_BYTES, // Control bytes, 0..4
  input wire logic [31:0] i_CTRL_BYTES, // Control bytes, first on top
  input wire logic [7:0] i_TX_DEST_ADDR, // Sent destination
  input wire logic [7:0] i_OWN_ADDR, // Own address
  input wire logic [7:0] i_BCAST_ADDR, // Broadcast address
  input wire logic [7:0] i_MCAST_ADDR, // Multicast address
  input wire logic i_DEST_FILT_EN, // Match own address
  input wire logic i_BCAST_FILT_EN, // Match broadcast
  input wire logic i_MCAST_FILT_EN, // Match multicast
  input wire logic i_SRC_FILT_EN, // Source filtering
  input wire logic [7:0] i_SRC_REF, // Source reference
  input wire logic [7:0] i_SRC_MASK, // Source mask
  input wire logic i_CRC_FILT_EN, // Drop bad CRC
  input wire logic [2:0] i_CRC_MODE, // CRC mode
  input wire logic i_SKIP_ACK_SETTING, // Sent no-ack bit
  input wire logic [1:0] i_SEQ_RELOAD_VALUE, // Sequence reload value
  input wire logic i_SEQ_RELOAD, // Sequence reload pulse
  input wire logic [7:0] i_PAYLOAD_LEN_LOW, // Length low byte
  input wire logic [7:0] i_PAYLOAD_LEN_HIGH, // Length high byte
  input wire logic [2:0] i_METER_SUBMODE_SELECT, // Meter submode
  input wire logic [7:0] i_METER_LEAD_IN_PAIRS, // Meter lead-in pairs
  input wire logic [7:0] i_METER_TRAILER_PAIRS, // Meter trailer pairs
  input wire logic i_TX_START, // Start a frame
  input wire logic [7:0] i_TX_DATA, // Payload byte
  input wire logic i_TX_DATA_VALID, // Payload byte valid
  output logic o_TX_DATA_READY, // Payload byte taken
  output logic o_TX_BIT, // Line bit
  output logic o_TX_BIT_VALID, // Line bit valid
  input wire logic i_TX_BIT_READY, // Line bit taken
  output logic o_TX_BUSY, // Frame in progress
  output logic o_TX_DONE, // Frame finished pulse
  output logic [1:0] o_SEQ_NUM, // Next sequence number
  input wire logic i_RX_BIT, // Received bit
  input wire logic i_RX_BIT_VALID, // Received bit valid
  output logic [7:0] o_RX_DATA, // Received payload byte
  output logic o_RX_DATA_VALID, // Byte valid pulse
  output logic o_RX_BUSY, // Frame being parsed
  output logic o_RX_DONE, // Frame end pulse
  output logic o_RX_ACCEPT, // Last frame passed filters
  output logic [1:0] o_RX_SEQ, // Received sequence number
  output logic o_RX_SKIP_ACK, // Received no-ack bit
  output logic [7:0] o_RX_SRC // Received source address
);
  field_e tx_state, tx_nxt, rx_state, rx_nxt;
  logic [19:0] tx_cnt, tx_nbits, rx_cnt, rx_nbits;
  logic [31:0] tx_sh, tx_nsh, tx_raw, rx_sh, rx_in, sync_all, smask;
  logic [4:0] tx_pend, crc_w;
  logic [23:0] tx_crc, rx_crc, tx_crc_after, rx_crc_after, crc_mask;
  logic [15:0] tx_plen, rx_plen, hdr, rx_lenv, rx_len;
  logic [1:0] seq;
  logic link, tx_stream, tx_emit, tx_done, rx_take, rx_done, rx_crc_ok;
  logic dest_ok, src_ok, any_dest;

  assign link = i_FRAME_FORMAT_SELECT == FMT_LINK;
  assign tx_plen = {i_PAYLOAD_LEN_HIGH, i_PAYLOAD_LEN_LOW};
  assign hdr = (link ? LINK_ADDR_BYTES : 16'(i_ADDR_FIELD_BYTES != 2'h0))
    + 16'(i_CTRL_FIELD_BYTES);
  assign sync_all = {i_SYNC_WORD_BYTE_A, i_SYNC_WORD_BYTE_B,
    i_SYNC_WORD_BYTE_C, i_SYNC_WORD_BYTE_D};

  always_comb begin
    unique case (i_CRC_MODE)
      3'h1: crc_w = 5'd8;
      3'h2, 3'h3: crc_w = 5'd16;
      3'h4: crc_w = 5'd24;
      default: crc_w = 5'd0;
    endcase
    crc_mask = 24'hffffff >> (5'd24 - crc_w);
  end

  function automatic logic [23:0] crc_next(logic [23:0] c, logic b);
    logic [23:0] p;
    logic fb;
    unique case (i_CRC_MODE)
      3'h1: begin p = POLY8; fb = b ^ c[7]; end
      3'h2: begin p = POLY16A; fb = b ^ c[15]; end
      3'h3: begin p = POLY16B; fb = b ^ c[15]; end
      3'h4: begin p = POLY24; fb = b ^ c[23]; end
      default: begin p = 24'h0; fb = 1'b0; end
    endcase
    return ((c << 1) ^ (fb ? p : 24'h0)) & crc_mask;
  endfunction

  // Bits in each field of the current frame
  function automatic logic [19:0] fbits(field_e f, logic [15:0] plen);
    logic [19:0] n;
    n = '0;
    unique case (f)
      F_IDLE: n = '0;
      F_PRE: n = 20'({i_PREAMBLE_BYTES_M1, 3'b000}) + 20'd8;
      F_SYNC: n = 20'({i_SYNC_BYTES_M1, 3'b000}) + 20'd8;
      F_LEN: n = i_VARIABLE_LENGTH_ENABLE ?
        20'(i_LENGTH_FIELD_BITS_MINUS_ONE) + 20'd1 : '0;
      F_DEST: n = (link || i_ADDR_FIELD_BYTES != 2'h0) ? ADDR_BITS : '0;
      F_SRC: n = link ? ADDR_BITS : '0;
      F_CTRL: n = 20'({i_CTRL_FIELD_BYTES, 3'b000});
      F_SEQ: n = link ? SEQ_BITS : '0;
      F_PAY: n = 20'({plen, 3'b000});
      F_CRC: n = 20'(crc_w);
      F_MPRE: begin
        unique case (i_METER_SUBMODE_SELECT)
          SUB_S: n = 20'(i_METER_LEAD_IN_PAIRS) + HDR_S;
          SUB_SM: n = 20'(i_METER_LEAD_IN_PAIRS) + HDR_SM;
          SUB_T: n = 20'(i_METER_LEAD_IN_PAIRS) + HDR_T;
          SUB_R: n = 20'(i_METER_LEAD_IN_PAIRS) + HDR_R;
          SUB_N: n = HDR_N;
          default: n = 20'(i_METER_LEAD_IN_PAIRS);
        endcase
        n = n << 1;
      end
      F_MSYNC: n = (i_METER_SUBMODE_SELECT == SUB_T) ?
        MSYNC_SHORT_BITS : MSYNC_LONG_BITS;
      F_MBODY: n = (i_METER_SUBMODE_SELECT == SUB_T) ?
        20'({plen, 3'b000}) + 20'({plen, 2'b00}) : 20'({plen, 4'h0});
      F_MPOST: n = 20'({i_METER_TRAILER_PAIRS, 1'b0});
    endcase
    return n;
  endfunction

  function automatic field_e succ(field_e f);
    unique case (f)
      F_IDLE: succ = (i_FRAME_FORMAT_SELECT == FMT_METER) ? F_MPRE : F_PRE;
      F_PRE: succ = F_SYNC;
      F_SYNC: succ = F_LEN;
      F_LEN: succ = F_DEST;
      F_DEST: succ = F_SRC;
      F_SRC: succ = F_CTRL;
      F_CTRL: succ = F_SEQ;
      F_SEQ: succ = F_PAY;
      F_PAY: succ = F_CRC;
      F_MPRE: succ = F_MSYNC;
      F_MSYNC: succ = F_MBODY;
      F_MBODY: succ = F_MPOST;
      F_CRC, F_MPOST: succ = F_IDLE;
    endcase
  endfunction

  // Next field that holds any bits
  function automatic field_e next_field(field_e f, logic [15:0] plen);
    field_e n;
    n = succ(f);
    for (int i = 0; i < 8; i++) begin
      if (n != F_IDLE && fbits(n, plen) == 20'd0) n = succ(n);
    end
    return n;
  endfunction

  function automatic logic [15:0] manch(logic [7:0] d);
    logic [15:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) m[2*i +: 2] = d[i] ? 2'b10 : 2'b01;
    return m;
  endfunction

  // Transmit field loading
  assign tx_stream = tx_state == F_PAY || tx_state == F_MBODY;
  assign o_TX_BIT_VALID = tx_state != F_IDLE && (!tx_stream || tx_pend != 0);
  assign o_TX_DATA_READY = tx_stream && tx_pend == 5'd0;
  assign o_TX_BIT = tx_sh[31];
  assign o_TX_BUSY = tx_state != F_IDLE;
  assign tx_emit = o_TX_BIT_VALID && i_TX_BIT_READY;
  assign tx_done = tx_emit && tx_cnt == 20'd1 && tx_nxt == F_IDLE;
  // CRC skips preamble and sync
  // Process form so settings read inside the functions retrigger it
  always_comb begin
    tx_crc_after = (tx_state inside {F_LEN, F_DEST, F_SRC, F_CTRL,
      F_SEQ, F_PAY}) ? crc_next(tx_crc, tx_sh[31]) : tx_crc;
    tx_nxt = next_field(tx_state, tx_plen);
    tx_nbits = fbits(tx_nxt, tx_plen);
  end
  always_comb begin
    unique case (tx_nxt)
      F_LEN: tx_raw = 32'(tx_plen + hdr);
      F_DEST: tx_raw = 32'(i_TX_DEST_ADDR);
      F_SRC: tx_raw = 32'(i_OWN_ADDR);
      F_SEQ: tx_raw = 32'({seq, i_SKIP_ACK_SETTING});
      F_CRC: tx_raw = 32'(tx_crc_after);
      F_MSYNC: tx_raw = (i_METER_SUBMODE_SELECT == SUB_T) ? MSYNC_SHORT :
        (i_METER_SUBMODE_SELECT == SUB_N) ? MSYNC_N : MSYNC_LONG;
      default: tx_raw = '0;
    endcase
    unique case (tx_nxt)
      F_PRE: tx_nsh = PRE_PATTERN;
      F_MPRE, F_MPOST: tx_nsh = PAIR_PATTERN;
      F_SYNC: tx_nsh = sync_all;
      F_CTRL: tx_nsh = i_CTRL_BYTES;
      default: tx_nsh = tx_raw << (6'd32 - 6'(tx_nbits));
    endcase
  end

  // Transmit sequencer, rotating MSB-first shifter
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      tx_state <= F_IDLE;
      tx_cnt <= '0;
      tx_sh <= '0;
      tx_pend <= '0;
      tx_crc <= '0;
    end else if (tx_state == F_IDLE) begin
      if (i_TX_START && i_FRAME_FORMAT_SELECT != 2'h1) begin
        tx_state <= tx_nxt;
        tx_cnt <= tx_nbits;
        tx_sh <= tx_nsh;
        tx_crc <= CRC_INIT & crc_mask;
      end
    end else if (tx_emit) begin
      tx_crc <= tx_crc_after;
      tx_pend <= '0;
      if (tx_cnt == 20'd1) begin
        tx_state <= tx_nxt;
        tx_cnt <= tx_nbits;
        tx_sh <= tx_nsh;
      end else begin
        tx_cnt <= tx_cnt - 20'd1;
        tx_sh <= {tx_sh[30:0], tx_sh[31]};
        if (tx_stream) tx_pend <= tx_pend - 5'd1;
      end
    end else if (o_TX_DATA_READY && i_TX_DATA_VALID) begin
      if (tx_state == F_PAY) begin
        tx_sh <= {i_TX_DATA, 24'h0};
        tx_pend <= BYTE_BITS;
      end else if (i_METER_SUBMODE_SELECT == SUB_T) begin
        tx_sh <= {SIX_TAB[i_TX_DATA[7:4]], SIX_TAB[i_TX_DATA[3:0]], 20'h0};
        tx_pend <= SIX_CHIPS;
      end else begin
        tx_sh <= {manch(i_TX_DATA), 16'h0};
        tx_pend <= MAN_CHIPS;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      seq <= '0;
      o_TX_DONE <= 1'b0;
    end else begin
      o_TX_DONE <= tx_done;
      if (i_SEQ_RELOAD) seq <= i_SEQ_RELOAD_VALUE;
      else if (tx_done && link) seq <= seq + 2'd1;
    end
  end
  assign o_SEQ_NUM = seq;

  // Receive decoding helpers
  assign rx_in = {rx_sh[30:0], i_RX_BIT};
  assign rx_take = i_RX_BIT_VALID && (link ||
    i_FRAME_FORMAT_SELECT == FMT_BASIC || rx_state != F_IDLE);
  assign smask = 32'hffffffff >> {~i_SYNC_BYTES_M1, 3'b000};
  assign rx_lenv = (rx_state == F_LEN) ? rx_in[15:0] &
    (16'hffff >> (4'hf - i_LENGTH_FIELD_BITS_MINUS_ONE)) : rx_len;
  assign rx_plen = !i_VARIABLE_LENGTH_ENABLE ? tx_plen :
    (rx_lenv > hdr) ? rx_lenv - hdr : 16'h0;
  // Next receive field and CRC step, retriggered by function inputs
  always_comb begin
    rx_crc_after = crc_next(rx_crc, i_RX_BIT);
    rx_nxt = next_field(rx_state == F_IDLE ? F_SYNC : rx_state, rx_plen);
    rx_nbits = fbits(rx_nxt, rx_plen);
  end
  assign rx_done = rx_take && rx_state != F_IDLE && rx_cnt == 20'd1 &&
    rx_nxt == F_IDLE;
  assign rx_crc_ok = crc_w == 5'd0 || rx_crc_after == 24'h0;
  assign any_dest = i_DEST_FILT_EN || i_BCAST_FILT_EN || i_MCAST_FILT_EN;
  assign o_RX_BUSY = rx_state != F_IDLE;

  // Receive sequencer: hunt sync, then parse fields
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rx_state <= F_IDLE;
      rx_cnt <= '0;
      rx_sh <= '0;
      rx_crc <= '0;
      rx_len <= '0;
    end else if (rx_take) begin
      rx_sh <= rx_in;
      if (rx_state == F_IDLE) begin
        if ((rx_in & smask) == ((sync_all >> {~i_SYNC_BYTES_M1, 3'b000})
            & smask) && rx_nxt != F_IDLE) begin
          rx_state <= rx_nxt;
          rx_cnt <= rx_nbits;
          rx_crc <= CRC_INIT & crc_mask;
        end
      end else begin
        rx_crc <= rx_crc_after;
        if (rx_state == F_LEN) rx_len <= rx_lenv;
        if (rx_cnt == 20'd1) begin
          rx_state <= rx_nxt;
          rx_cnt <= rx_nbits;
        end else begin
          rx_cnt <= rx_cnt - 20'd1;
        end
      end
    end
  end

  // Filter results and received fields
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      dest_ok <= 1'b1;
      src_ok <= 1'b1;
      o_RX_DATA <= '0;
      o_RX_DATA_VALID <= 1'b0;
      o_RX_DONE <= 1'b0;
      o_RX_ACCEPT <= 1'b0;
      o_RX_SEQ <= '0;
      o_RX_SKIP_ACK <= 1'b0;
      o_RX_SRC <= '0;
    end else begin
      o_RX_DATA_VALID <= rx_take && rx_state == F_PAY && rx_cnt[2:0] == 3'h1;
      o_RX_DONE <= rx_done;
      if (rx_take && rx_state == F_IDLE) begin
        dest_ok <= 1'b1;
        src_ok <= 1'b1;
      end
      if (rx_take && rx_state == F_PAY && rx_cnt[2:0] == 3'h1)
        o_RX_DATA <= rx_in[7:0];
      if (rx_take && rx_cnt == 20'd1) begin
        if (rx_state == F_DEST) dest_ok <= !any_dest ||
          (i_DEST_FILT_EN && rx_in[7:0] == i_OWN_ADDR) ||
          (i_BCAST_FILT_EN && rx_in[7:0] == i_BCAST_ADDR) ||
          (i_MCAST_FILT_EN && rx_in[7:0] == i_MCAST_ADDR);
        if (rx_state == F_SRC) begin
          o_RX_SRC <= rx_in[7:0];
          src_ok <= !i_SRC_FILT_EN ||
            (rx_in[7:0] & i_SRC_MASK) == (i_SRC_REF & i_SRC_MASK);
        end
        if (rx_state == F_SEQ) {o_RX_SEQ, o_RX_SKIP_ACK} <= rx_in[2:0];
      end
      if (rx_done) o_RX_ACCEPT <= dest_ok && src_ok &&
        (!i_CRC_FILT_EN || rx_crc_ok);
    end
  end

  property p_fmt_ignored;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (tx_state == F_IDLE && i_FRAME_FORMAT_SELECT == 2'h1) |=>
      tx_state == F_IDLE;
  endproperty
  a_fmt_ignored: assert property (p_fmt_ignored)
    else $error("Start taken with unknown format");
  property p_pre_start;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (tx_state == F_IDLE && i_TX_START && link) |=>
      (tx_state == F_PRE && o_TX_BIT && tx_cnt[2:0] == 3'h0);
  endproperty
  a_pre_start: assert property (p_pre_start)
    else $error("Preamble did not start with a one");
  property p_sync_len;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (tx_state == F_SYNC && $past(tx_state) != F_SYNC) |->
      tx_cnt == 20'({i_SYNC_BYTES_M1, 3'b000}) + 20'd8;
  endproperty
  a_sync_len: assert property (p_sync_len)
    else $error("Sync length wrong");
  property p_length_field_bits_minus_one;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (tx_state == F_LEN && $past(tx_state) != F_LEN) |->
      tx_cnt == 20'(i_LENGTH_FIELD_BITS_MINUS_ONE) + 20'd1;
  endproperty
  a_length_field_bits_minus_one: assert property (p_length_field_bits_minus_one)
    else $error("Length field width wrong");
  property p_seq_inc;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (tx_done && link && !i_SEQ_RELOAD) |=> seq == $past(seq) + 2'd1;
  endproperty
  a_seq_inc: assert property (p_seq_inc)
    else $error("Sequence did not advance");
  property p_seq_reload;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
      i_SEQ_RELOAD |=> seq == $past(i_SEQ_RELOAD_VALUE);
  endproperty
  a_seq_reload: assert property (p_seq_reload)
    else $error("Sequence reload lost");
  property p_pay_len;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (tx_state == F_PAY && $past(tx_state) != F_PAY) |->
      tx_cnt == 20'({tx_plen, 3'b000});
  endproperty
  a_pay_len: assert property (p_pay_len)
    else $error("Payload length wrong");
  property p_crc_drop;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (rx_done && i_CRC_FILT_EN && !rx_crc_ok) |=> ##0 !o_RX_ACCEPT;
  endproperty
  a_crc_drop: assert property (p_crc_drop)
    else $error("Bad CRC frame accepted");
  property p_msync;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
      (tx_state == F_MSYNC && $past(tx_state) != F_MSYNC) |->
      tx_cnt == ((i_METER_SUBMODE_SELECT == SUB_T) ? 20'd10 : 20'd18);
  endproperty
  a_msync: assert property (p_msync)
    else $error("Meter sync length wrong");
endmodule

//--- tb/radio_peer.sv
// Peer radio model: captures line bits, plays them back to the receiver
`timescale 1ns/1ns
module radio_peer (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic tx_bit, // Line bit from framer
  input wire logic tx_valid, // Line bit valid
  output logic tx_ready, // Line bit taken
  input wire logic replay, // Start playback pulse
  input wire logic [9:0] flip_idx, // Bit index to corrupt
  output logic rx_bit, // Bit to receiver
  output logic rx_valid, // Bit valid
  output logic [9:0] n_cap // Bits captured
);
  logic cap [1024];
  logic [9:0] pos;
  logic play;
  // Capture line bits, stalling every other cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
      n_cap <= '0;
    end else begin
      tx_ready <= ~tx_ready;
      if (tx_valid && tx_ready) begin
        cap[n_cap] <= tx_bit;
        n_cap <= n_cap + 10'h1;
      end
    end
  end
  // Playback at half rate; idle line toggles so stale values never match
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      play <= 1'b0;
      pos <= '0;
      rx_valid <= 1'b0;
      rx_bit <= 1'b0;
    end else if (replay) begin
      play <= 1'b1;
      pos <= '0;
      rx_valid <= 1'b0;
    end else if (play && !rx_valid) begin
      rx_bit <= cap[pos] ^ (pos == flip_idx);
      rx_valid <= 1'b1;
    end else begin
      rx_valid <= 1'b0;
      rx_bit <= ~rx_bit;
      if (rx_valid) begin
        pos <= pos + 10'h1;
        play <= (pos + 10'h1 != n_cap);
      end
    end
  end
endmodule

//--- tb/radio_packet_framer_tb.sv
// Self-checking bench: link and meter frames, loopback, filters, sequence
`timescale 1ns/1ns
module radio_packet_framer_tb;
  import radio_packet_framer_pkg::*;
  logic I_SYS_CLK = 1'b0, I_NRST = 1'b0;
  logic [1:0] i_FRAME_FORMAT_SELECT = FMT_BASIC, i_SYNC_BYTES_M1 = 2'h1;
  logic [4:0] i_PREAMBLE_BYTES_M1 = 5'h01;
  logic [7:0] i_SYNC_WORD_BYTE_A = 8'hd3, i_SYNC_WORD_BYTE_B = 8'h91;
  logic [7:0] i_SYNC_WORD_BYTE_C = 8'h0f, i_SYNC_WORD_BYTE_D = 8'hf0;
  logic i_VARIABLE_LENGTH_ENABLE = 1'b1, i_SRC_FILT_EN = 1'b1;
  logic [3:0] i_LENGTH_FIELD_BITS_MINUS_ONE = 4'h7;
  logic [1:0] i_ADDR_FIELD_BYTES = 2'h2, i_SEQ_RELOAD_VALUE = 2'h2;
  logic [2:0] i_CTRL_FIELD_BYTES = 3'h1, i_CRC_MODE = 3'h1;
  logic [31:0] i_CTRL_BYTES = 32'h6e000000;
  logic [7:0] i_TX_DEST_ADDR = 8'h42, i_OWN_ADDR = 8'h42;
  logic [7:0] i_BCAST_ADDR = 8'hff, i_MCAST_ADDR = 8'hee;
  logic i_DEST_FILT_EN = 1'b1, i_BCAST_FILT_EN = 1'b1;
  logic i_MCAST_FILT_EN = 1'b0, i_CRC_FILT_EN = 1'b1;
  logic [7:0] i_SRC_REF = 8'h42, i_SRC_MASK = 8'hff;
  // no-ack only set with link format
  logic i_SKIP_ACK_SETTING = 1'b0, i_SEQ_RELOAD = 1'b0;
  logic [7:0] i_PAYLOAD_LEN_LOW = 8'h02, i_PAYLOAD_LEN_HIGH = 8'h00;
  logic [2:0] i_METER_SUBMODE_SELECT = SUB_T;
  logic [7:0] i_METER_LEAD_IN_PAIRS = 8'h04, i_METER_TRAILER_PAIRS = 8'h02;
  logic i_TX_START = 1'b0, i_TX_DATA_VALID = 1'b1;
  logic [7:0] i_TX_DATA = 8'h3c;
  logic o_TX_DATA_READY, o_TX_BIT, o_TX_BIT_VALID, i_TX_BIT_READY;
  logic o_TX_BUSY, o_TX_DONE, i_RX_BIT, i_RX_BIT_VALID;
  logic o_RX_DATA_VALID, o_RX_BUSY, o_RX_DONE, o_RX_ACCEPT, o_RX_SKIP_ACK;
  logic [1:0] o_SEQ_NUM, o_RX_SEQ;
  logic [7:0] o_RX_DATA, o_RX_SRC;
  logic replay = 1'b0;
  logic [9:0] flip_idx = 10'h3ff, n_cap;
  // Two link payload bytes, then one meter body byte
  logic [7:0] pay [4] = '{8'h3c, 8'hc5, 8'h5a, 8'h00};
  logic exp_q [$];
  logic [7:0] rx_q [$];
  logic [7:0] crc;
  int pi = 0, cyc = 0, error_cnt = 0, check_count = 0, s, k;
  radio_packet_framer radio_packet_framer_inst (.*);
  radio_peer radio_peer_inst (.clk(I_SYS_CLK), .nrst(I_NRST),
    .tx_bit(o_TX_BIT), .tx_valid(o_TX_BIT_VALID), .tx_ready(i_TX_BIT_READY),
    .replay(replay), .flip_idx(flip_idx), .rx_bit(i_RX_BIT),
    .rx_valid(i_RX_BIT_VALID), .n_cap(n_cap));
  // Clock and cycle ceiling
  always #5 I_SYS_CLK = ~I_SYS_CLK;
  always @(posedge I_SYS_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  // Payload feeder and received byte collector
  always @(posedge I_SYS_CLK) begin
    if (o_TX_DATA_READY === 1'b1) begin
      pi <= pi + 1;
      i_TX_DATA <= pay[pi+1];
    end
    if (o_RX_DATA_VALID === 1'b1) rx_q.push_back(o_RX_DATA);
  end
  task check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task put(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) exp_q.push_back(v[i]);
  endtask
  task strobe_start();
    @(posedge I_SYS_CLK) i_TX_START <= 1'b1;
    @(posedge I_SYS_CLK) i_TX_START <= 1'b0;
  endtask
  task run_rx(input logic [9:0] idx);
    rx_q = {};
    @(posedge I_SYS_CLK) begin
      flip_idx <= idx;
      replay <= 1'b1;
    end
    @(posedge I_SYS_CLK) replay <= 1'b0;
    for (k = 0; k < 3000 && o_RX_DONE !== 1'b1; k++) @(negedge I_SYS_CLK);
    check("rx done", o_RX_DONE, 1'b1);
    check("rx idle", o_RX_BUSY, 1'b0);
  endtask
  task test_done();
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge I_SYS_CLK);
    I_NRST <= 1'b1;
    i_FRAME_FORMAT_SELECT <= 2'h1;
    strobe_start();
    repeat (2) @(negedge I_SYS_CLK);
    check("busy on format 1", o_TX_BUSY, 1'b0);
    @(posedge I_SYS_CLK) begin
      i_FRAME_FORMAT_SELECT <= FMT_LINK;
      i_SKIP_ACK_SETTING <= 1'b1;
    end
    strobe_start();
    for (k = 0; k < 3000 && o_TX_DONE !== 1'b1; k++) @(negedge I_SYS_CLK);
    check("tx done", o_TX_DONE, 1'b1);
    check("seq after frame", o_SEQ_NUM, 2'h1);
    put(PRE_PATTERN[7:0], 8);
    put(PRE_PATTERN[7:0], 8);
    put(8'hd3, 8);
    put(8'h91, 8);
    s = exp_q.size();
    put(8'h05, 8);
    put(8'h42, 8);
    put(8'h42, 8);
    put(8'h6e, 8);
    put(3'h1, 3);
    put(8'h3c, 8);
    put(8'hc5, 8);
    crc = 8'hff;
    for (int i = s; i < exp_q.size(); i++)
      crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ exp_q[i]) ? 8'h07 : 8'h00);
    put(crc, 8);
    check("bit count", n_cap, exp_q.size());
    for (int i = 0; i < exp_q.size(); i++)
      check("line bit", radio_peer_inst.cap[i], exp_q[i]);
    run_rx(10'h3ff);
    check("rx accept", o_RX_ACCEPT, 1'b1);
    check("rx source", o_RX_SRC, 8'h42);
    check("rx seq", o_RX_SEQ, 2'h0);
    check("rx no-ack", o_RX_SKIP_ACK, 1'b1);
    check("rx bytes", rx_q.size(), 2);
    check("rx byte 0", rx_q[0], 8'h3c);
    check("rx byte 1", rx_q[1], 8'hc5);
    run_rx(10'(s + 55));
    check("bad crc accept", o_RX_ACCEPT, 1'b0);
    @(posedge I_SYS_CLK) i_SRC_REF <= 8'h43;
    run_rx(10'h3ff);
    check("source mismatch", o_RX_ACCEPT, 1'b0);
    @(posedge I_SYS_CLK) i_SEQ_RELOAD <= 1'b1;
    @(posedge I_SYS_CLK) i_SEQ_RELOAD <= 1'b0;
    @(negedge I_SYS_CLK);
    check("seq reload", o_SEQ_NUM, 2'h2);
    // Meter frame, submode 3, one body byte
    @(posedge I_SYS_CLK) begin
      i_SKIP_ACK_SETTING <= 1'b0;
      i_FRAME_FORMAT_SELECT <= FMT_METER;
      i_PAYLOAD_LEN_LOW <= 8'h01;
    end
    s = n_cap;
    exp_q = {};
    strobe_start();
    for (k = 0; k < 3000 && o_TX_DONE !== 1'b1; k++) @(negedge I_SYS_CLK);
    check("meter done", o_TX_DONE, 1'b1);
    check("meter seq kept", o_SEQ_NUM, 2'h2);
    put(PAIR_PATTERN, 32);
    put(PAIR_PATTERN, 14);
    put(MSYNC_SHORT, 10);
    put(32'(SIX_TAB[4'h5]), 6);
    put(32'(SIX_TAB[4'ha]), 6);
    put(PAIR_PATTERN, 4);
    check("meter bits", n_cap - s, exp_q.size());
    for (int i = 0; i < exp_q.size(); i++)
      check("meter bit", radio_peer_inst.cap[s + i], exp_q[i]);
    test_done();
  end
endmodule
